// file: logic/cnfem_map.svh
// Register offsets, field positions and timing constants of the error monitor
`ifndef CNFEM_MAP_SVH
`define CNFEM_MAP_SVH
`define CNFEM_CLK_HZ 10000000
`define CNFEM_WDT_MS 100
`define CNFEM_STRETCH_MS 600
`define CNFEM_TICK_US 100
`define CNFEM_TICK_CYC ((`CNFEM_CLK_HZ / 1000000) * `CNFEM_TICK_US)
`define CNFEM_WDT_CYC ((`CNFEM_CLK_HZ / 1000) * `CNFEM_WDT_MS)
`define CNFEM_STRETCH_CYC ((`CNFEM_CLK_HZ / 1000) * `CNFEM_STRETCH_MS)
`define CNFEM_BLINK_TICKS 16'd2500
`define CNFEM_ADDR_CTRL 8'h00
`define CNFEM_ADDR_STATUS 8'h04
`define CNFEM_ADDR_CODE 8'h08
`define CNFEM_ADDR_FLAGS 8'h0C
`define CNFEM_ADDR_AVG 8'h10
`define CNFEM_ADDR_LAST 8'h14
`define CNFEM_CTRL_WDT_OFF 2
`define CNFEM_CTRL_RESET 32'h00000000
`define CNFEM_FLG_SETUP_BOOT 0
`define CNFEM_FLG_SETUP_RUN 1
`define CNFEM_FLG_SETUP_OPER 2
`define CNFEM_FLG_OVERRUN 3
`define CNFEM_FLG_LINK_ACTIVITY_INDICATOR 4
`define CNFEM_FLG_BACKUP 5
`define CNFEM_FLG_USER 6
`define CNFEM_NFLAGS 7
`define CNFEM_CODE_SETUP 8'h9B
`define CNFEM_CODE_OVERRUN 8'hF8
`define CNFEM_CODE_NONE 8'h00
`define CNFEM_ALARM_CLEAR 8'h00
`define CNFEM_ALARM_MAX 8'h99
`endif

// file: logic/cnfem_monitor.sv
// Cycle sequencer and non-fatal error monitor of the controller
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "cnfem_map.svh"

module cnfem_monitor #(
    parameter int WDT_CYC = `CNFEM_WDT_CYC,
    parameter int STRETCH_CYC = `CNFEM_STRETCH_CYC,
    parameter int TICK_CYC = `CNFEM_TICK_CYC
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output cnfem_pkg::cnfem_phase_t phase,
    input wire logic phase_done,
    output logic area_clear,
    output logic timer_preset,
    input wire logic io_units_ok,
    input wire logic fatal_error,
    output logic exec_enable,
    input wire cnfem_pkg::cnfem_alarm_t user_nonfatal_alarm_instr,
    input wire cnfem_pkg::cnfem_setup_t setup_check,
    input wire logic link_fault,
    input wire logic backup_lost,
    input wire logic rewrite_busy,
    input wire logic nv_changed,
    output logic flash_commit,
    input wire logic flash_commit_done,
    output logic irq_block,
    output cnfem_pkg::cnfem_leds_t leds
);
    import cnfem_pkg::*;
    if (WDT_CYC < 2 || STRETCH_CYC < 2 || TICK_CYC < 1) begin : g_param_check
        $error("cnfem_monitor: timing parameters too small");
    end

    logic link_fault_s1_reg, link_fault_reg, backup_lost_s1_reg, backup_lost_reg;
    logic [31:0] ctrl_reg, stretch_cnt_reg, wdt_cnt_reg, tick_cnt_reg, reg_rdata_reg;
    cnfem_mode_t mode_reg, mode_prev_reg;
    cnfem_phase_t phase_reg;
    logic [1:0] init_step_reg;
    logic nv_dirty_reg, commit_wait_reg, cycle_stretched_reg, overrun_seen_reg, tick_reg, blink_reg, boot_check_reg;
    logic [15:0] cyc_ticks_reg, last_ticks_reg, blink_cnt_reg;
    // Average held as eight times the cycle ticks
    logic [18:0] avg_ticks_reg;
    logic [`CNFEM_NFLAGS-1:0] flags_reg, flag_set, flag_clr;
    logic [7:0] code_reg, code_next;
    logic running, cycle_start, run_entry, wdt_fire, user_clear;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    assign running = (mode_reg != CNFEM_MODE_PROGRAM);
    assign cycle_start = (phase_reg == CNFEM_PH_SERVICE) && phase_done;
    assign run_entry = (mode_reg == CNFEM_MODE_RUN) && (mode_prev_reg != CNFEM_MODE_RUN);
    assign user_clear = user_nonfatal_alarm_instr.exec && (user_nonfatal_alarm_instr.number == `CNFEM_ALARM_CLEAR);
    // The link fault and backup lost pins pass two flip-flops
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            link_fault_s1_reg <= 1'b0;
            link_fault_reg <= 1'b0;
            backup_lost_s1_reg <= 1'b0;
            backup_lost_reg <= 1'b0;
        end else begin
            link_fault_s1_reg <= link_fault;
            link_fault_reg <= link_fault_s1_reg;
            backup_lost_s1_reg <= backup_lost;
            backup_lost_reg <= backup_lost_s1_reg;
        end
    end
    // Control register and mode
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ctrl_reg <= `CNFEM_CTRL_RESET;
            mode_reg <= CNFEM_MODE_PROGRAM;
            mode_prev_reg <= CNFEM_MODE_PROGRAM;
        end else begin
            mode_prev_reg <= mode_reg;
            if (reg_wr && hit(reg_addr, `CNFEM_ADDR_CTRL)) begin
                ctrl_reg <= {29'h0000000, reg_wdata[2:0]};
                case (reg_wdata[1:0])
                    2'h1: mode_reg <= CNFEM_MODE_MONITOR;
                    2'h2: mode_reg <= CNFEM_MODE_RUN;
                    default: mode_reg <= CNFEM_MODE_PROGRAM;
                endcase
            end
        end
    end
    // Cycle sequencer
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            phase_reg <= CNFEM_PH_INIT;
            init_step_reg <= 2'h0;
            area_clear <= 1'b0;
            timer_preset <= 1'b0;
            boot_check_reg <= 1'b0;
        end else begin
            area_clear <= 1'b0;
            timer_preset <= 1'b0;
            boot_check_reg <= 1'b0;
            if (fatal_error) begin
                phase_reg <= CNFEM_PH_HALT;
            end else begin
                case (phase_reg)
                    CNFEM_PH_INIT: begin
                        case (init_step_reg)
                            2'h0: begin
                                area_clear <= 1'b1;
                                timer_preset <= 1'b1;
                                boot_check_reg <= 1'b1;
                                init_step_reg <= 2'h1;
                            end
                            2'h1: begin
                                if (!io_units_ok) begin
                                    phase_reg <= CNFEM_PH_HALT;
                                end else begin
                                    init_step_reg <= 2'h2;
                                end
                            end
                            default: begin
                                if (!commit_wait_reg) begin
                                    phase_reg <= CNFEM_PH_OVERSEE;
                                end
                            end
                        endcase
                    end
                    CNFEM_PH_OVERSEE: if (phase_done) phase_reg <= CNFEM_PH_EXECUTE;
                    CNFEM_PH_EXECUTE: if (phase_done) phase_reg <= CNFEM_PH_IO_REFRESH;
                    CNFEM_PH_IO_REFRESH: if (phase_done) phase_reg <= CNFEM_PH_SERVICE;
                    CNFEM_PH_SERVICE: if (phase_done) phase_reg <= CNFEM_PH_OVERSEE;
                    CNFEM_PH_HALT: phase_reg <= CNFEM_PH_HALT;
                    default: phase_reg <= CNFEM_PH_HALT;
                endcase
            end
        end
    end
    // Flash commit of changed nonvolatile data
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            nv_dirty_reg <= 1'b1;
            commit_wait_reg <= 1'b0;
            flash_commit <= 1'b0;
        end else begin
            flash_commit <= 1'b0;
            if (commit_wait_reg) begin
                if (flash_commit_done) begin
                    commit_wait_reg <= 1'b0;
                end
            end else if (nv_dirty_reg && running && (mode_prev_reg == CNFEM_MODE_PROGRAM)) begin
                flash_commit <= 1'b1;
                commit_wait_reg <= 1'b1;
                nv_dirty_reg <= 1'b0;
            end else if (nv_dirty_reg && boot_check_reg) begin
                flash_commit <= 1'b1;
                commit_wait_reg <= 1'b1;
                nv_dirty_reg <= 1'b0;
            end
            if (nv_changed) begin
                nv_dirty_reg <= 1'b1;
            end
        end
    end
    // Online rewrite stretch window
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            stretch_cnt_reg <= 32'h00000000;
            irq_block <= 1'b0;
        end else if (rewrite_busy && running && (stretch_cnt_reg < STRETCH_CYC)) begin
            stretch_cnt_reg <= stretch_cnt_reg + 32'h00000001;
            irq_block <= 1'b1;
        end else begin
            if (!rewrite_busy) begin
                stretch_cnt_reg <= 32'h00000000;
            end
            irq_block <= 1'b0;
        end
    end
    // Cycle watchdog
    assign wdt_fire = (wdt_cnt_reg == WDT_CYC) && !overrun_seen_reg && !cycle_stretched_reg
        && !ctrl_reg[`CNFEM_CTRL_WDT_OFF];
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            wdt_cnt_reg <= 32'h00000000;
            cycle_stretched_reg <= 1'b0;
            overrun_seen_reg <= 1'b0;
        end else if (cycle_start || phase_reg == CNFEM_PH_INIT) begin
            wdt_cnt_reg <= 32'h00000001;
            cycle_stretched_reg <= rewrite_busy && running;
            overrun_seen_reg <= 1'b0;
        end else begin
            if (wdt_cnt_reg < WDT_CYC) begin
                wdt_cnt_reg <= wdt_cnt_reg + 32'h00000001;
            end
            if (rewrite_busy && running) begin
                cycle_stretched_reg <= 1'b1;
            end
            if (wdt_fire) begin
                overrun_seen_reg <= 1'b1;
            end
        end
    end
    // Cycle time measurement in 100 us ticks
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            tick_cnt_reg <= 32'h00000000;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == TICK_CYC - 1) begin
            tick_cnt_reg <= 32'h00000000;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
            tick_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cyc_ticks_reg <= 16'h0000;
            last_ticks_reg <= 16'h0000;
            avg_ticks_reg <= 19'h00000;
        end else if (cycle_start) begin
            cyc_ticks_reg <= {15'h0000, tick_reg};
            last_ticks_reg <= cyc_ticks_reg;
            avg_ticks_reg <= avg_ticks_reg - {3'h0, avg_ticks_reg[18:3]} + {3'h0, cyc_ticks_reg};
        end else if (tick_reg && cyc_ticks_reg != 16'hFFFF) begin
            cyc_ticks_reg <= cyc_ticks_reg + 16'h0001;
        end
    end
    // Sticky error flags, set wins over clear
    always_comb begin
        flag_set = '0;
        flag_set[`CNFEM_FLG_SETUP_BOOT] = boot_check_reg && setup_check.boot_bad;
        flag_set[`CNFEM_FLG_SETUP_RUN] = run_entry && setup_check.run_bad;
        flag_set[`CNFEM_FLG_SETUP_OPER] = running && phase_reg != CNFEM_PH_INIT && setup_check.oper_bad;
        flag_set[`CNFEM_FLG_OVERRUN] = wdt_fire;
        flag_set[`CNFEM_FLG_LINK_ACTIVITY_INDICATOR] = link_fault_reg;
        flag_set[`CNFEM_FLG_BACKUP] = backup_lost_reg;
        flag_set[`CNFEM_FLG_USER] = user_nonfatal_alarm_instr.exec && !user_clear
            && user_nonfatal_alarm_instr.number <= `CNFEM_ALARM_MAX;
        flag_clr = '0;
        if (reg_wr && hit(reg_addr, `CNFEM_ADDR_FLAGS)) begin
            flag_clr = reg_wdata[`CNFEM_NFLAGS-1:0];
        end
        flag_clr[`CNFEM_FLG_USER] = flag_clr[`CNFEM_FLG_USER] | user_clear;
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= (flags_reg & ~flag_clr) | flag_set;
        end
    end
    // Error code word, latest setup, overrun or user alarm detection wins
    always_comb begin
        code_next = code_reg;
        if (user_clear && flags_reg[`CNFEM_FLG_USER] && code_reg != `CNFEM_CODE_SETUP
            && code_reg != `CNFEM_CODE_OVERRUN) begin
            code_next = `CNFEM_CODE_NONE;
        end
        if (reg_wr && hit(reg_addr, `CNFEM_ADDR_CODE)) begin
            code_next = `CNFEM_CODE_NONE;
        end
        if (flag_set[`CNFEM_FLG_USER]) begin
            code_next = user_nonfatal_alarm_instr.number;
        end
        if (|flag_set[`CNFEM_FLG_SETUP_OPER:`CNFEM_FLG_SETUP_BOOT]) begin
            code_next = `CNFEM_CODE_SETUP;
        end
        if (flag_set[`CNFEM_FLG_OVERRUN]) begin
            code_next = `CNFEM_CODE_OVERRUN;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            code_reg <= `CNFEM_CODE_NONE;
        end else begin
            code_reg <= code_next;
        end
    end
    // Register read port
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            reg_rdata_reg <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `CNFEM_ADDR_CTRL: reg_rdata_reg <= ctrl_reg;
                `CNFEM_ADDR_STATUS: reg_rdata_reg <= {26'h0000000, nv_dirty_reg, irq_block, 1'b0, phase_reg};
                `CNFEM_ADDR_CODE: reg_rdata_reg <= {24'h000000, code_reg};
                `CNFEM_ADDR_FLAGS: reg_rdata_reg <= {25'h0000000, flags_reg};
                `CNFEM_ADDR_AVG: reg_rdata_reg <= {16'h0000, avg_ticks_reg[18:3]};
                `CNFEM_ADDR_LAST: reg_rdata_reg <= {16'h0000, last_ticks_reg};
                default: reg_rdata_reg <= 32'h00000000;
            endcase
        end else begin
            reg_rdata_reg <= 32'h00000000;
        end
    end
    assign reg_rdata = reg_rdata_reg;
    // Indicators and phase outputs
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            blink_cnt_reg <= 16'h0000;
            blink_reg <= 1'b0;
        end else if (tick_reg) begin
            if (blink_cnt_reg == `CNFEM_BLINK_TICKS - 16'h0001) begin
                blink_cnt_reg <= 16'h0000;
                blink_reg <= ~blink_reg;
            end else begin
                blink_cnt_reg <= blink_cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            leds <= '0;
            phase <= CNFEM_PH_INIT;
            exec_enable <= 1'b0;
        end else begin
            phase <= phase_reg;
            exec_enable <= running && phase_reg == CNFEM_PH_EXECUTE;
            leds.power <= phase_reg != CNFEM_PH_HALT;
            leds.run <= running && phase_reg != CNFEM_PH_HALT;
            if (phase_reg == CNFEM_PH_HALT) begin
                leds.error_alarm <= 1'b1;
            end else begin
                leds.error_alarm <= blink_reg && (|(flags_reg & ~(7'h01 << `CNFEM_FLG_LINK_ACTIVITY_INDICATOR)));
            end
            leds.link_activity <= !flags_reg[`CNFEM_FLG_LINK_ACTIVITY_INDICATOR];
        end
    end
endmodule

// file: logic/cnfem_pkg.sv
// Types shared by the error monitor and its users
package cnfem_pkg;
    typedef enum logic [1:0] {
        CNFEM_MODE_PROGRAM,
        CNFEM_MODE_MONITOR,
        CNFEM_MODE_RUN
    } cnfem_mode_t;
    typedef enum logic [2:0] {
        CNFEM_PH_INIT,
        CNFEM_PH_OVERSEE,
        CNFEM_PH_EXECUTE,
        CNFEM_PH_IO_REFRESH,
        CNFEM_PH_SERVICE,
        CNFEM_PH_HALT
    } cnfem_phase_t;
    typedef struct packed {
        logic exec;
        logic [7:0] number;
    } cnfem_alarm_t;
    typedef struct packed {
        logic boot_bad;
        logic run_bad;
        logic oper_bad;
    } cnfem_setup_t;
    typedef struct packed {
        logic power;
        logic run;
        logic error_alarm;
        logic link_activity;
    } cnfem_leds_t;
endpackage

// file: tb/cnfem_assertions.sv
// Checker of cycle order, init pulses and non-fatal error reactions
`timescale 1ns/1ps
`include "cnfem_map.svh"
module cnfem_assertions (
    input logic sys_clk,
    input logic nrst,
    input logic [7:0] reg_addr,
    input logic reg_wr,
    input cnfem_pkg::cnfem_phase_t phase,
    input logic area_clear,
    input logic timer_preset,
    input logic fatal_error,
    input logic exec_enable,
    input cnfem_pkg::cnfem_alarm_t user_nonfatal_alarm_instr,
    input logic link_fault,
    input logic rewrite_busy,
    input logic flash_commit,
    input logic irq_block,
    input cnfem_pkg::cnfem_leds_t leds
);
    import cnfem_pkg::*;
    logic [3:0] since_wr_reg;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Clocks since the last mode register write
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            since_wr_reg <= 4'hF;
        end else if (reg_wr && reg_addr == `CNFEM_ADDR_CTRL) begin
            since_wr_reg <= 4'h0;
        end else if (since_wr_reg != 4'hF) begin
            since_wr_reg <= since_wr_reg + 4'h1;
        end
    end
    sequence s_fault_held;
        link_fault [*4];
    endsequence
    sequence s_alarm_running;
        user_nonfatal_alarm_instr.exec && !fatal_error && !$past(fatal_error)
            && phase != CNFEM_PH_INIT && phase != CNFEM_PH_HALT ##1 !fatal_error [*2];
    endsequence
    property p_alarm_keeps_running;
        s_alarm_running |-> phase != CNFEM_PH_HALT;
    endproperty
    a_alarm_keeps_running: assert property (p_alarm_keeps_running) else $error("alarm halted the cycle");
    property p_phase_order;
        phase != $past(phase) && phase != CNFEM_PH_INIT && phase != CNFEM_PH_HALT && $past(phase) != CNFEM_PH_INIT
            |-> phase == ($past(phase) == CNFEM_PH_SERVICE ? CNFEM_PH_OVERSEE : cnfem_phase_t'($past(phase) + 3'd1));
    endproperty
    a_phase_order: assert property (p_phase_order) else $error("phase order broken");
    property p_init_pulse;
        area_clear |-> timer_preset && phase == CNFEM_PH_INIT ##1 !area_clear;
    endproperty
    a_init_pulse: assert property (p_init_pulse) else $error("init pulse wrong");
    property p_fatal_halt;
        fatal_error |-> ##[1:3] phase == CNFEM_PH_HALT;
    endproperty
    a_fatal_halt: assert property (p_fatal_halt) else $error("fatal error did not halt");
    property p_exec_window;
        exec_enable |-> phase == CNFEM_PH_EXECUTE;
    endproperty
    a_exec_window: assert property (p_exec_window) else $error("execution outside its phase");
    property p_power_lit;
        phase inside {CNFEM_PH_EXECUTE, CNFEM_PH_IO_REFRESH, CNFEM_PH_SERVICE} |-> leds.power;
    endproperty
    a_power_lit: assert property (p_power_lit) else $error("power indicator dark while cycling");
    property p_link_off;
        s_fault_held |-> ##[0:3] !leds.link_activity;
    endproperty
    a_link_off: assert property (p_link_off) else $error("link indicator lit during fault");
    property p_irq_cause;
        irq_block |-> $past(rewrite_busy);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupts blocked without rewrite");
    property p_commit_cause;
        flash_commit |-> phase == CNFEM_PH_INIT || since_wr_reg < 4'd6;
    endproperty
    a_commit_cause: assert property (p_commit_cause) else $error("flash commit without cause");
endmodule

// file: tb/cnfem_engine_model.sv
// Program engine and flash store model answering phase and commit requests
`timescale 1ns/1ps
module cnfem_engine_model (
    input logic sys_clk,
    input logic nrst,
    input cnfem_pkg::cnfem_phase_t phase,
    input logic stall,
    input logic flash_commit,
    output logic phase_done,
    output logic flash_commit_done
);
    import cnfem_pkg::*;
    logic [1:0] step_reg;
    logic [2:0] flash_reg;
    // Each phase but init and halt finishes on every third clock unless stalled
    always_ff @(posedge sys_clk) begin
        if (!nrst || stall || phase == CNFEM_PH_INIT || phase == CNFEM_PH_HALT) begin
            step_reg <= 2'd0;
            phase_done <= 1'b0;
        end else begin
            step_reg <= (step_reg == 2'd2) ? 2'd0 : step_reg + 2'd1;
            phase_done <= (step_reg == 2'd2);
        end
    end
    // Flash write lasts five clocks, then one done pulse
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            flash_reg <= 3'd0;
            flash_commit_done <= 1'b0;
        end else if (flash_commit) begin
            flash_reg <= 3'd5;
            flash_commit_done <= 1'b0;
        end else begin
            flash_reg <= (flash_reg != 3'd0) ? flash_reg - 3'd1 : 3'd0;
            flash_commit_done <= (flash_reg == 3'd1);
        end
    end
endmodule

// file: tb/tb_top.sv
// Self-checking bench of the error monitor
`timescale 1ns/1ps
`include "cnfem_map.svh"
module tb_top;
    import cnfem_pkg::*;
    logic sys_clk = 0;
    logic nrst = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, commits = 0, d;
    logic reg_wr = 0, reg_rd = 0, phase_done, area_clear, timer_preset, io_units_ok = 1, fatal_error = 0;
    logic exec_enable, link_fault = 0, backup_lost = 0, rewrite_busy = 0, nv_changed = 0, flash_commit;
    logic flash_commit_done, irq_block, stall = 0, seen_clear = 0, seen_exec = 0;
    cnfem_phase_t phase;
    cnfem_alarm_t user_nonfatal_alarm_instr = '0;
    cnfem_setup_t setup_check = 3'b100;
    cnfem_leds_t leds;
    logic [7:0] nums [3] = '{8'h01, 8'h42, 8'h99};
    int miscompares = 0, tests_run = 0;
    cnfem_monitor #(.WDT_CYC(200), .STRETCH_CYC(50), .TICK_CYC(4)) dut (.*);
    cnfem_engine_model engine (.*);
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (area_clear) seen_clear <= 1'b1;
        if (exec_enable) seen_exec <= 1'b1;
        if (flash_commit) commits <= commits + 32'h1;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t ns: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task results;
        $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
        check(d, exp);
    endtask
    task clear_errors;
        wr(`CNFEM_ADDR_FLAGS, 32'h7F);
        wr(`CNFEM_ADDR_CODE, 32'h0);
    endtask
    task alarm(input logic [7:0] n);
        @(posedge sys_clk);
        user_nonfatal_alarm_instr <= '{exec: 1'b1, number: n};
        @(posedge sys_clk);
        user_nonfatal_alarm_instr.exec <= 1'b0;
    endtask
    task wait_alarm(input logic v);
        for (int i = 0; i < 12000 && leds.error_alarm !== v; i++) @(posedge sys_clk);
        if (leds.error_alarm !== v) begin
            miscompares++;
            results();
        end
    endtask
    task wait_phase(input cnfem_phase_t p);
        for (int i = 0; i < 500 && phase !== p; i++) @(posedge sys_clk);
        if (phase !== p) begin
            miscompares++;
            results();
        end
    endtask
    initial begin
        idle(4);
        nrst <= 1'b1;
        wait_phase(CNFEM_PH_OVERSEE);
        setup_check.boot_bad <= 1'b0;
        check(seen_clear, 1);
        check(commits, 1);
        rdc(`CNFEM_ADDR_FLAGS, 32'h01);
        rdc(`CNFEM_ADDR_CODE, 32'h9B);
        rdc(`CNFEM_ADDR_CTRL, `CNFEM_CTRL_RESET);
        clear_errors();
        rdc(`CNFEM_ADDR_FLAGS, 32'h0);
        @(posedge sys_clk);
        nv_changed <= 1'b1;
        setup_check.run_bad <= 1'b1;
        @(posedge sys_clk);
        nv_changed <= 1'b0;
        wr(`CNFEM_ADDR_CTRL, 32'h2);
        idle(20);
        setup_check.run_bad <= 1'b0;
        check(commits, 2);
        rdc(`CNFEM_ADDR_FLAGS, 32'h02);
        clear_errors();
        setup_check.oper_bad <= 1'b1;
        idle(3);
        setup_check.oper_bad <= 1'b0;
        rdc(`CNFEM_ADDR_FLAGS, 32'h04);
        rdc(`CNFEM_ADDR_CODE, 32'h9B);
        clear_errors();
        foreach (nums[i]) begin
            alarm(nums[i]);
            rdc(`CNFEM_ADDR_CODE, {24'h0, nums[i]});
            check(leds.power && leds.run, 1'b1);
        end
        rdc(`CNFEM_ADDR_FLAGS, 32'h40);
        alarm(8'h00);
        rdc(`CNFEM_ADDR_CODE, 32'h0);
        rdc(`CNFEM_ADDR_FLAGS, 32'h0);
        check(seen_exec, 1);
        stall <= 1'b1;
        idle(300);
        stall <= 1'b0;
        rdc(`CNFEM_ADDR_FLAGS, 32'h08);
        rdc(`CNFEM_ADDR_CODE, 32'hF8);
        clear_errors();
        wr(`CNFEM_ADDR_CTRL, 32'h6);
        stall <= 1'b1;
        idle(300);
        stall <= 1'b0;
        idle(20);
        rdc(`CNFEM_ADDR_FLAGS, 32'h0);
        wr(`CNFEM_ADDR_CTRL, 32'h2);
        rewrite_busy <= 1'b1;
        stall <= 1'b1;
        idle(10);
        check(irq_block, 1'b1);
        idle(290);
        check(irq_block, 1'b0);
        rewrite_busy <= 1'b0;
        stall <= 1'b0;
        idle(20);
        rdc(`CNFEM_ADDR_FLAGS, 32'h0);
        link_fault <= 1'b1;
        idle(10);
        check(leds.link_activity, 1'b0);
        link_fault <= 1'b0;
        backup_lost <= 1'b1;
        idle(10);
        backup_lost <= 1'b0;
        rdc(`CNFEM_ADDR_CODE, 32'h0);
        rdc(`CNFEM_ADDR_FLAGS, 32'h30);
        wait_alarm(1'b1);
        check(leds.error_alarm, 1'b1);
        wait_alarm(1'b0);
        check(leds.error_alarm, 1'b0);
        wr(`CNFEM_ADDR_FLAGS, 32'h30);
        rdc(8'h20, 32'h0);
        // Twelve clocks per cycle, four clocks per tick
        rdc(`CNFEM_ADDR_AVG, 32'h3);
        rdc(`CNFEM_ADDR_LAST, 32'h3);
        fatal_error <= 1'b1;
        wait_phase(CNFEM_PH_HALT);
        check(phase, CNFEM_PH_HALT);
        results();
    end
endmodule
bind cnfem_monitor cnfem_assertions u_chk (.*);
